// ===== inc/led_matrix_pkg.sv
package led_matrix_pkg;
  localparam int ROWS = 4;
  localparam int COLS = 18;
  localparam int DOTS = 72;
  // Page selectors and register offsets
  localparam logic [7:0] DUTY_PAGE = 8'h40;
  localparam logic [7:0] FUNCTION_PAGE = 8'h41;
  localparam logic [7:0] DOT_BASE = 8'h01;
  localparam logic [7:0] DOT_LAST = 8'h48;
  localparam logic [7:0] CONFIG_OFS = 8'h50;
  localparam logic [7:0] CURRENT_OFS = 8'h51;
  localparam logic [7:0] PULL_OFS = 8'h52;
  localparam logic [7:0] FAULT_BASE = 8'h53;
  localparam logic [7:0] FAULT_LAST = 8'h5e;
  localparam logic [7:0] THERMAL_OFS = 8'h5f;
  localparam logic [7:0] SPREAD_OFS = 8'h60;
  localparam logic [7:0] RESET_OFS = 8'h8f;
  localparam logic [7:0] UNLOCK_OFS = 8'he0;
  localparam logic [7:0] FREQ_OFS = 8'he2;
  // Reset values, write masks and keys
  localparam logic [7:0] PULL_RST = 8'h33;
  localparam logic [7:0] RESET_KEY = 8'hae;
  localparam logic [7:0] CONFIG_MASK = 8'hf7;
  localparam logic [7:0] PULL_MASK = 8'hf7;
  localparam logic [7:0] THERMAL_MASK = 8'h0f;
  localparam logic [7:0] SPREAD_MASK = 8'h1f;
  localparam logic [7:0] UNLOCK_MASK = 8'h01;
  localparam logic [7:0] FREQ_MASK = 8'he0;
  // Scan select and fault detect codes
  localparam logic [3:0] SCAN_THREE = 4'h1;
  localparam logic [3:0] SCAN_TWO = 4'h2;
  localparam logic [3:0] SCAN_NONE = 4'h3;
  localparam logic [1:0] FAULT_OFF = 2'h0;
  localparam logic [1:0] FAULT_SHORT = 2'h2;
  // Scan timing
  localparam int CLK_PS = 10000;
  localparam int SCAN_PS = 33000000;
  localparam int BLANKING_GAP_PS = 830000;
  localparam int COLUMN_STAGGER_PS = 300000;
  localparam int SLOT_CYC = (SCAN_PS + CLK_PS - 1) / CLK_PS;
  localparam int GAP_CYC = (BLANKING_GAP_PS + CLK_PS - 1) / CLK_PS;
  localparam int STAGGER_CYC = COLUMN_STAGGER_PS / CLK_PS;
  localparam logic [1:0] DETECT_FRAMES = 2'h2;
  // Thermal and spread tables
  localparam logic [6:0] FULL_PCT = 7'h64;
  localparam logic [6:0] DERATE_PCT [4] = '{7'h64, 7'h4b, 7'h37, 7'h1e};
  localparam logic [7:0] THRESH_C [4] = '{8'h8c, 8'h78, 8'h64, 8'h5a};
  localparam logic [5:0] SPREAD_PCT [4] = '{6'h05, 6'h0f, 6'h18, 6'h22};
  localparam logic [10:0] SPREAD_US [4] = '{11'h7bc, 11'h4b0, 11'h334, 11'h294};
  typedef enum logic [0:0] {SLOT = 1'b0, GAP = 1'b1} scan_state_t;
endpackage : led_matrix_pkg

// ===== hw/led_matrix_scan_pwm_regs.sv
`timescale 1ns/1ps
// Function
// - Page 0 holds 8-bit duty per dot; on-time is value/256 of slot.
// - Page 1 holds 8-bit current scale per dot, 256 steps.
// - Global current level multiplies every dot's scale for all eighteen sinks.
// - Config bit 0 low is shutdown, high runs; resets low.
// - Fault field 00 off, 01 or 11 open test, 10 short test.
// - A test runs once; writing 00 then nonzero rearms it.
// - Twelve read-only result registers, six columns each, bits 7:6 zero.
// - Scan field picks four, three, two rows, or no scan.
// - Pull register bit 7 selects 0 or 180 degree phase.
// - Row pulldown and column pullup fields, off-time or continuous, reset 011.
// - Die temperature at threshold derates output current.
// - Derate field gives 100, 75, 55, 30 percent.
// - Threshold field gives 140, 120, 100, 90 degrees.
// - Spread enable bit gates range and period fields.
// - Range field gives 5, 15, 24, 34 percent deviation.
// - Period field gives 1980, 1200, 820, 660 microseconds.
// - Writing 0xAE to reset register restores every register default.
// - Power-up reset gives defaults, display blank.
// - Frequency select writes land only while unlock bit is set.
// - Frequency code 000/111 fastest, each step halves, 110 slowest.
// - Rows on in turn per 33 us slot, 0.83 us gap, columns staggered.
// - Shutdown turns all sinks off, registers stay accessible.
// - Results valid after two scan frame ends, the first frame possibly partial; zero-scale dots untouched.
module led_matrix_scan_pwm_regs
  import led_matrix_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Matrix drive
  output logic [ROWS-1:0] row_switch,
  output logic [COLS-1:0] column_sink,
  output logic [COLS*8-1:0] column_sink_level,
  output logic [ROWS-1:0] row_pulldown_on,
  output logic [COLS-1:0] column_pullup_on,
  output logic [2:0] row_pulldown_select,
  output logic [2:0] column_pullup_select,
  // Analog sense and trims
  input wire logic [COLS-1:0] column_fault_sense,
  input wire logic [7:0] die_temp_c,
  output logic [6:0] current_derate_pct,
  output logic fault_test_active,
  output logic fault_test_short,
  output logic spread_enable,
  output logic [5:0] spread_range,
  output logic [10:0] spread_period,
  output logic [2:0] pwm_freq_shift
);
  logic [7:0] duty_r [DOTS];
  logic [7:0] duty_nxt [DOTS];
  logic [7:0] scale_r [DOTS];
  logic [7:0] scale_nxt [DOTS];
  logic [DOTS-1:0] fault_r, fault_nxt;
  logic [7:0] cfg_r, cfg_nxt, gcl_r, gcl_nxt, pull_r, pull_nxt;
  logic [7:0] therm_r, therm_nxt, spread_r, spread_nxt;
  logic [7:0] unlock_r, unlock_nxt, freq_r, freq_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic soft_rst, wr_func, wr_duty, dot_hit;
  logic [7:0] dot_ofs, fault_ofs;
  logic [6:0] dot_idx;
  logic [3:0] fault_k;

  assign soft_rst = reg_wr && reg_page == FUNCTION_PAGE && reg_addr == RESET_OFS && reg_wdata == RESET_KEY;
  assign wr_func = reg_wr && reg_page == FUNCTION_PAGE;
  assign wr_duty = reg_wr && reg_page == DUTY_PAGE;
  assign dot_ofs = reg_addr - DOT_BASE;
  assign dot_idx = dot_ofs[6:0];
  assign dot_hit = reg_addr >= DOT_BASE && reg_addr <= DOT_LAST;
  assign fault_ofs = reg_addr - FAULT_BASE;
  assign fault_k = fault_ofs[3:0];

  // Scan engine state
  scan_state_t state_r, state_nxt;
  logic [1:0] row_r, row_nxt;
  logic [17:0] cnt_r, cnt_nxt, slot_len;
  logic [2:0] nrows;
  logic no_scan, frame_end;
  logic [2:0] shift;
  // Fault detection state
  logic armed_r, armed_nxt, det_run_r, det_run_nxt, det_short_r, det_short_nxt;
  logic [1:0] det_frames_r, det_frames_nxt;
  logic [1:0] fault_mode;

  assign fault_mode = cfg_r[2:1];
  assign no_scan = cfg_r[7:4] == SCAN_NONE;
  assign shift = (freq_r[7:5] == 3'h7) ? 3'h0 : freq_r[7:5];
  // Slower PWM stretches the slot so the duty resolution stays 256 steps
  assign slot_len = 18'(SLOT_CYC) << shift;

  always_comb begin
    unique case (cfg_r[7:4])
      SCAN_THREE: nrows = 3'h3;
      SCAN_TWO: nrows = 3'h2;
      default: nrows = 3'h4;
    endcase
  end

  // Register file
  always_comb begin
    duty_nxt = duty_r;
    scale_nxt = scale_r;
    fault_nxt = fault_r;
    cfg_nxt = cfg_r;
    gcl_nxt = gcl_r;
    pull_nxt = pull_r;
    therm_nxt = therm_r;
    spread_nxt = spread_r;
    unlock_nxt = unlock_r;
    freq_nxt = freq_r;
    if (wr_duty && dot_hit) begin
      duty_nxt[dot_idx] = reg_wdata;
    end
    if (wr_func) begin
      if (dot_hit) begin
        scale_nxt[dot_idx] = reg_wdata;
      end
      unique case (reg_addr)
        CONFIG_OFS: cfg_nxt = reg_wdata & CONFIG_MASK;
        CURRENT_OFS: gcl_nxt = reg_wdata;
        PULL_OFS: pull_nxt = reg_wdata & PULL_MASK;
        THERMAL_OFS: therm_nxt = reg_wdata & THERMAL_MASK;
        SPREAD_OFS: spread_nxt = reg_wdata & SPREAD_MASK;
        UNLOCK_OFS: unlock_nxt = reg_wdata & UNLOCK_MASK;
        FREQ_OFS: begin
          if (unlock_r[0]) begin
            freq_nxt = reg_wdata & FREQ_MASK;
          end
        end
        default: begin
        end
      endcase
    end
    // Result capture at each slot end; zero-scale dots keep old data
    if (det_run_r && state_r == SLOT && cnt_r == slot_len - 18'h1) begin
      for (int c = 0; c < COLS; c++) begin
        if (scale_r[7'(row_r * COLS + c)] != 8'h00) begin
          fault_nxt[7'(row_r * COLS + c)] = column_fault_sense[c];
        end
      end
    end
    if (rst || soft_rst) begin
      for (int i = 0; i < DOTS; i++) begin
        duty_nxt[i] = 8'h00;
        scale_nxt[i] = 8'h00;
      end
      fault_nxt = '0;
      cfg_nxt = 8'h00;
      gcl_nxt = 8'h00;
      pull_nxt = PULL_RST;
      therm_nxt = 8'h00;
      spread_nxt = 8'h00;
      unlock_nxt = 8'h00;
      freq_nxt = 8'h00;
    end
  end

  // Read port, answer one cycle after the strobe
  always_comb begin
    rvalid_nxt = reg_rd && !rst;
    rdata_nxt = 8'h00;
    if (reg_rd && reg_page == DUTY_PAGE && dot_hit) begin
      rdata_nxt = duty_r[dot_idx];
    end else if (reg_rd && reg_page == FUNCTION_PAGE) begin
      if (dot_hit) begin
        rdata_nxt = scale_r[dot_idx];
      end else if (reg_addr >= FAULT_BASE && reg_addr <= FAULT_LAST) begin
        rdata_nxt = {2'b00, fault_r[7'(fault_k / 4'h3) * 7'(COLS) + 7'(fault_k % 4'h3) * 7'h6 +: 6]};
      end else begin
        unique case (reg_addr)
          CONFIG_OFS: rdata_nxt = cfg_r;
          CURRENT_OFS: rdata_nxt = gcl_r;
          PULL_OFS: rdata_nxt = pull_r;
          THERMAL_OFS: rdata_nxt = therm_r;
          SPREAD_OFS: rdata_nxt = spread_r;
          default: rdata_nxt = 8'h00;
        endcase
      end
    end
  end

  // Scan sequencer
  always_comb begin
    state_nxt = state_r;
    row_nxt = row_r;
    cnt_nxt = cnt_r + 18'h1;
    frame_end = 1'b0;
    unique case (state_r)
      SLOT: begin
        if (cnt_r >= slot_len - 18'h1) begin
          state_nxt = GAP;
          cnt_nxt = 18'h0;
        end
      end
      GAP: begin
        if (cnt_r == 18'(GAP_CYC - 1)) begin
          state_nxt = SLOT;
          cnt_nxt = 18'h0;
          if (3'(row_r) + 3'h1 >= nrows) begin
            row_nxt = 2'h0;
            frame_end = 1'b1;
          end else begin
            row_nxt = row_r + 2'h1;
          end
        end
      end
    endcase
    if (rst) begin
      state_nxt = SLOT;
      row_nxt = 2'h0;
      cnt_nxt = 18'h0;
    end
  end

  // Detection trigger, one shot per 00-to-nonzero move
  always_comb begin
    armed_nxt = armed_r;
    det_run_nxt = det_run_r;
    det_frames_nxt = det_frames_r;
    det_short_nxt = det_short_r;
    if (fault_mode == FAULT_OFF) begin
      armed_nxt = 1'b1;
    end else if (armed_r) begin
      armed_nxt = 1'b0;
      det_run_nxt = 1'b1;
      det_frames_nxt = 2'h0;
      det_short_nxt = fault_mode == FAULT_SHORT;
    end
    if (det_run_r && frame_end) begin
      det_frames_nxt = det_frames_r + 2'h1;
      if (det_frames_r + 2'h1 == DETECT_FRAMES) begin
        det_run_nxt = 1'b0;
      end
    end
    if (rst || soft_rst) begin
      armed_nxt = 1'b0;
      det_run_nxt = 1'b0;
      det_frames_nxt = 2'h0;
      det_short_nxt = 1'b0;
    end
  end

  // Output drive
  logic [ROWS-1:0] row_switch_nxt, row_pulldown_nxt;
  logic [COLS-1:0] sink_nxt, pullup_nxt;
  logic [COLS*8-1:0] level_nxt;
  logic [6:0] derate_nxt;
  logic row_live;

  assign row_live = no_scan || 3'(row_r) < nrows;

  genvar g;
  generate
    for (g = 0; g < COLS; g++) begin : col_g
      localparam int DELAY = g * STAGGER_CYC / (COLS - 1);
      logic [6:0] dot;
      logic [25:0] prod;
      logic [17:0] thr, rel;
      logic [15:0] lvl;
      logic on;
      assign dot = no_scan ? 7'(g) : 7'(row_r * COLS + g);
      assign prod = 26'(duty_r[dot]) * 26'(slot_len);
      assign thr = prod[25:8];
      assign rel = cnt_r - 18'(DELAY);
      always_comb begin
        on = 1'b0;
        if (state_r == SLOT && cnt_r >= 18'(DELAY) && row_live) begin
          if (pull_r[7] && g % 2 == 1) begin
            on = rel >= slot_len - thr;
          end else begin
            on = rel < thr;
          end
        end
      end
      assign sink_nxt[g] = on && cfg_r[0] && !rst;
      assign lvl = 16'(scale_r[dot]) * 16'(gcl_r);
      assign level_nxt[g*8 +: 8] = rst ? 8'h00 : lvl[15:8];
      assign pullup_nxt[g] = !rst && pull_r[2:0] != 3'h0 && (pull_r[2] || !on);
    end
    for (g = 0; g < ROWS; g++) begin : row_g
      assign row_switch_nxt[g] = !rst && !no_scan && state_r == SLOT && row_r == 2'(g) && row_live;
      assign row_pulldown_nxt[g] = !rst && pull_r[6:4] != 3'h0 && (pull_r[6] || !row_switch_nxt[g]);
    end
  endgenerate

  // Die at or above threshold pulls current down to the chosen share
  assign derate_nxt = rst ? FULL_PCT : (die_temp_c >= THRESH_C[therm_r[3:2]]) ? DERATE_PCT[therm_r[1:0]] : FULL_PCT;

  always_ff @(posedge clock) begin
    duty_r <= duty_nxt;
    scale_r <= scale_nxt;
    fault_r <= fault_nxt;
    cfg_r <= cfg_nxt;
    gcl_r <= gcl_nxt;
    pull_r <= pull_nxt;
    therm_r <= therm_nxt;
    spread_r <= spread_nxt;
    unlock_r <= unlock_nxt;
    freq_r <= freq_nxt;
    rdata_r <= rdata_nxt;
    rvalid_r <= rvalid_nxt;
    state_r <= state_nxt;
    row_r <= row_nxt;
    cnt_r <= cnt_nxt;
    armed_r <= armed_nxt;
    det_run_r <= det_run_nxt;
    det_frames_r <= det_frames_nxt;
    det_short_r <= det_short_nxt;
    row_switch <= row_switch_nxt;
    column_sink <= sink_nxt;
    column_sink_level <= level_nxt;
    row_pulldown_on <= row_pulldown_nxt;
    column_pullup_on <= pullup_nxt;
    current_derate_pct <= derate_nxt;
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign row_pulldown_select = pull_r[6:4];
  assign column_pullup_select = pull_r[2:0];
  assign fault_test_active = det_run_r;
  assign fault_test_short = det_short_r;
  // Range and period show zero while spread is off
  assign spread_enable = spread_r[4];
  assign spread_range = spread_r[4] ? SPREAD_PCT[spread_r[3:2]] : 6'h00;
  assign spread_period = spread_r[4] ? SPREAD_US[spread_r[1:0]] : 11'h000;
  assign pwm_freq_shift = shift;

  // Checks
  sequence slot_to_gap;
    state_r == SLOT ##1 state_r == GAP;
  endsequence
  sequence trigger_write;
    fault_mode == FAULT_OFF ##1 fault_mode != FAULT_OFF;
  endsequence

  shutdown_blank_a: assert property (@(posedge clock) disable iff (rst) !cfg_r[0] |=> column_sink == '0)
    else $error("sink on during shutdown");
  gap_dark_a: assert property (@(posedge clock) disable iff (rst) slot_to_gap |-> ##1 (row_switch == '0 && column_sink == '0) [*8])
    else $error("outputs on during blanking gap");
  soft_reset_a: assert property (@(posedge clock) disable iff (rst) soft_rst |=> cfg_r == 8'h00 && pull_r == PULL_RST && gcl_r == 8'h00)
    else $error("soft reset missed a register");
  freq_lock_a: assert property (@(posedge clock) disable iff (rst) wr_func && reg_addr == FREQ_OFS && !unlock_r[0] |=> $stable(freq_r))
    else $error("frequency changed while locked");
  detect_start_a: assert property (@(posedge clock) disable iff (rst || soft_rst) trigger_write |=> det_run_r && det_frames_r == 2'h0)
    else $error("detection did not start");
  detect_once_a: assert property (@(posedge clock) disable iff (rst) !armed_r && !det_run_r && fault_mode != FAULT_OFF |=> !det_run_r)
    else $error("detection retriggered without clear");
  detect_end_a: assert property (@(posedge clock) disable iff (rst) $fell(det_run_r) && !$past(soft_rst) |-> $past(frame_end) && $past(det_frames_r) == 2'h1)
    else $error("detection ended early");
  fault_read_a: assert property (@(posedge clock) disable iff (rst) reg_rd && reg_page == FUNCTION_PAGE && reg_addr >= FAULT_BASE && reg_addr <= FAULT_LAST |=> reg_rvalid && reg_rdata[7:6] == 2'b00)
    else $error("result register reserved bits set");
  two_rows_a: assert property (@(posedge clock) disable iff (rst) cfg_r[7:4] == SCAN_TWO |=> row_switch[3:2] == 2'b00)
    else $error("inactive row switched on");
  derate_a: assert property (@(posedge clock) disable iff (rst) die_temp_c < THRESH_C[therm_r[3:2]] |=> current_derate_pct == FULL_PCT)
    else $error("derate without heat");
endmodule : led_matrix_scan_pwm_regs

// ===== testbench/led_matrix_model.sv
`timescale 1ns/1ps
module led_matrix_model
  import led_matrix_pkg::*;
(
  // Row drive
  input wire logic [ROWS-1:0] row_switch,
  // Faulty dots, row major
  input wire logic [ROWS*COLS-1:0] open_map,
  // Comparator outputs
  output logic [COLS-1:0] column_fault_sense
);
  // Only a powered row can trip a column; idle rows report nothing
  always_comb begin
    column_fault_sense = '0;
    for (int r = 0; r < ROWS; r++) begin
      if (row_switch[r]) begin
        column_fault_sense = column_fault_sense | open_map[r*COLS +: COLS];
      end
    end
  end
endmodule : led_matrix_model

// ===== testbench/tb_led_matrix_scan_pwm_regs.sv
`timescale 1ns/1ps
module tb_led_matrix_scan_pwm_regs;
  import led_matrix_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_page = 8'h00;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [ROWS-1:0] row_switch;
  logic [COLS-1:0] column_sink;
  logic [COLS*8-1:0] column_sink_level;
  logic [ROWS-1:0] row_pulldown_on;
  logic [COLS-1:0] column_pullup_on;
  logic [2:0] row_pulldown_select;
  logic [2:0] column_pullup_select;
  logic [COLS-1:0] column_fault_sense;
  logic [7:0] die_temp_c = 8'h19;
  logic [6:0] current_derate_pct;
  logic fault_test_active;
  logic fault_test_short;
  logic spread_enable;
  logic [5:0] spread_range;
  logic [10:0] spread_period;
  logic [2:0] pwm_freq_shift;
  logic [ROWS*COLS-1:0] open_map = '0;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  int sink_cnt = 0;
  int n = 0;
  localparam logic [7:0] THR [4] = '{8'h8c, 8'h78, 8'h64, 8'h5a};
  localparam logic [6:0] PCT [4] = '{7'h64, 7'h4b, 7'h37, 7'h1e};
  localparam logic [5:0] SS_RANGE [4] = '{6'h05, 6'h0f, 6'h18, 6'h22};
  localparam logic [10:0] PER [4] = '{11'h7bc, 11'h4b0, 11'h334, 11'h294};
  localparam logic [7:0] RA [11] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h5e, 8'h5f, 8'h60, 8'h8f, 8'he0, 8'he2, 8'h70};
  localparam logic [7:0] MA [5] = '{8'h50, 8'h52, 8'h5f, 8'h60, 8'h55};
  localparam logic [7:0] MW [5] = '{8'hf9, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] MX [5] = '{8'hf1, 8'hf7, 8'h0f, 8'h1f, 8'h00};

  led_matrix_scan_pwm_regs dut (
    .clock, .rst, .reg_page, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
    .row_switch, .column_sink, .column_sink_level, .row_pulldown_on, .column_pullup_on,
    .row_pulldown_select, .column_pullup_select, .column_fault_sense, .die_temp_c,
    .current_derate_pct, .fault_test_active, .fault_test_short, .spread_enable, .spread_range,
    .spread_period, .pwm_freq_shift
  );
  led_matrix_model matrix (.row_switch, .open_map, .column_fault_sense);

  always #5 clock = ~clock;

  // Sampled mid-cycle so registered outputs have settled
  always @(negedge clock) begin
    if (row_switch[0] && column_sink[0]) begin
      sink_cnt++;
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 95000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_page <= pg;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_page <= pg;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", reg_rvalid, 16'h1);
    chk($sformatf("reg %h/%h", pg, a), reg_rdata, exp);
  endtask : rdchk

  // Bounded wait for a row pattern; n returns the cycles spent
  task automatic wait_rs(input logic [3:0] want);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (row_switch !== want && n < 20000);
    chk("row_wait", row_switch, want);
  endtask : wait_rs

  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("pd_sel", row_pulldown_select, 16'h3);
    chk("pu_sel", column_pullup_select, 16'h3);
    chk("derate", current_derate_pct, 16'h64);
    for (int i = 0; i < 11; i++) begin
      rdchk(8'h41, RA[i], (RA[i] == 8'h52) ? 8'h33 : 8'h00);
    end
    rdchk(8'h40, 8'h48, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(8'h41, MA[i], MW[i]);
      rdchk(8'h41, MA[i], MX[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h41, 8'h60, 8'h10 | 8'(i * 5));
      #1;
      chk("ss_en", spread_enable, 16'h1);
      chk("ss_range", spread_range, SS_RANGE[i]);
      chk("ss_per", spread_period, PER[i]);
    end
    wr(8'h41, 8'h60, 8'h0f);
    #1;
    chk("ss_off", {spread_enable, spread_range, spread_period}, 16'h0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h41, 8'h5f, 8'(i * 5));
      die_temp_c <= THR[i] - 8'h01;
      repeat (3) @(posedge clock);
      #1;
      chk("below", current_derate_pct, 16'h64);
      @(posedge clock);
      die_temp_c <= THR[i];
      repeat (3) @(posedge clock);
      #1;
      chk("derate", current_derate_pct, PCT[i]);
    end
    @(posedge clock);
    die_temp_c <= 8'h19;
    // Locked select must not move the rate
    wr(8'h41, 8'he2, 8'h20);
    repeat (2) @(posedge clock);
    #1;
    chk("locked", pwm_freq_shift, 16'h0);
    wr(8'h41, 8'he0, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(8'h41, 8'he2, 8'(i << 5));
      repeat (2) @(posedge clock);
      #1;
      chk("freq", pwm_freq_shift, (i == 7) ? 16'h0 : 16'(i));
    end
    rdchk(8'h41, 8'he0, 8'h00);
    wr(8'h40, 8'h01, 8'ha5);
    wr(8'h41, 8'h01, 8'h5a);
    rdchk(8'h40, 8'h01, 8'ha5);
    rdchk(8'h41, 8'h01, 8'h5a);
    wr(8'h41, 8'h8f, 8'hae);
    rdchk(8'h41, 8'h52, 8'h33);
    rdchk(8'h40, 8'h01, 8'h00);
    rdchk(8'h41, 8'h01, 8'h00);
    // Scan: shutdown first, then three rows
    wr(8'h40, 8'h01, 8'h80);
    wr(8'h41, 8'h01, 8'h80);
    wr(8'h41, 8'h51, 8'h80);
    wait_rs(4'h0);
    wait_rs(4'h1);
    repeat (100) @(posedge clock);
    #1;
    chk("sink_off", column_sink, 16'h0);
    wr(8'h41, 8'h50, 8'h11);
    wait_rs(4'h0);
    wait_rs(4'h1);
    sink_cnt = 0;
    repeat (4) @(posedge clock);
    #1;
    chk("level", column_sink_level[7:0], 16'h40);
    chk("pulldown", row_pulldown_on, 32'he);
    chk("pullup", column_pullup_on, 32'h3fffe);
    wait_rs(4'h0);
    chk("slot", 16'(n + 4), 16'hce4);
    chk("on_time", 16'(sink_cnt), 16'h672);
    wait_rs(4'h2);
    chk("gap", 16'(n), 16'h53);
    wait_rs(4'h0);
    wait_rs(4'h4);
    wait_rs(4'h0);
    wait_rs(4'h1);
    chk("wrap", 16'(n), 16'h53);
    // Half-turn phase moves odd columns to the slot end
    wr(8'h41, 8'h52, 8'h80);
    wr(8'h40, 8'h02, 8'h80);
    repeat (2) @(posedge clock);
    #1;
    chk("phase_early", column_sink[1:0], 32'h1);
    repeat (3000) @(posedge clock);
    #1;
    chk("phase_late", column_sink[1:0], 32'h2);
    wr(8'h41, 8'h50, 8'h31);
    repeat (3) @(posedge clock);
    #1;
    chk("no_scan", row_switch, 16'h0);
    wr(8'h41, 8'h50, 8'h21);
    wait_rs(4'h2);
    wait_rs(4'h0);
    wait_rs(4'h1);
    chk("two_rows", 16'(n), 32'h53);
    // Detection with one open dot scaled and one left at zero scale
    wr(8'h41, 8'h50, 8'h01);
    wr(8'h41, 8'h51, 8'h20);
    wr(8'h41, 8'h52, 8'h00);
    wr(8'h40, 8'h1a, 8'hff);
    wr(8'h41, 8'h1a, 8'h40);
    open_map <= 72'h2040000;
    wr(8'h41, 8'h50, 8'h03);
    repeat (2) @(posedge clock);
    #1;
    chk("active", fault_test_active, 16'h1);
    chk("short", fault_test_short, 16'h0);
    chk("pulls_off", {row_pulldown_on, column_pullup_on}, 32'h0);
    n = 0;
    while (fault_test_active === 1'b1 && n < 50000) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("done", fault_test_active, 16'h0);
    rdchk(8'h41, 8'h57, 8'h02);
    rdchk(8'h41, 8'h56, 8'h00);
    // Without passing through 00 nothing restarts
    wr(8'h41, 8'h50, 8'h05);
    repeat (2) @(posedge clock);
    #1;
    chk("no_rearm", fault_test_active, 16'h0);
    wr(8'h41, 8'h8f, 8'hae);
    rdchk(8'h41, 8'h57, 8'h00);
    for (int i = 1; i < 4; i++) begin
      wr(8'h41, 8'h8f, 8'hae);
      wr(8'h41, 8'h50, 8'h01);
      wr(8'h41, 8'h50, 8'h01 | 8'(i << 1));
      repeat (2) @(posedge clock);
      #1;
      chk("mode_act", fault_test_active, 16'h1);
      chk("mode_short", fault_test_short, (i == 2) ? 16'h1 : 16'h0);
    end
    wr(8'h41, 8'h8f, 8'hae);
    repeat (2) @(posedge clock);
    #1;
    chk("abort", fault_test_active, 16'h0);
    final_report();
  end
endmodule : tb_led_matrix_scan_pwm_regs
